/* File: hw/xrb_top.sv */
// expanded register bank: apb slave, reset pin control, stop-mode retention
`timescale 1ns/1ps
module xrb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_level,
  output xrb_pkg::xrb_pin_s reset_pin,
  input wire logic brownout,
  input wire logic watchdog_timeout,
  input wire logic stop_enter,
  input wire logic stop_wake,
  input wire xrb_pkg::xrb_cap_s capture,
  output logic [7:0] bank_group_pointer,
  output logic stop_mode,
  output logic device_reset,
  output logic recovery_reset
);
  import xrb_pkg::*;

  // --------------------------------
  // input synchronisers
  // --------------------------------

  logic pin_s1_ff;
  logic pin_s2_ff;
  logic lowv_s1_ff;
  logic lowv_s2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
    end else begin
      pin_s1_ff <= reset_pin_level;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowv_s1_ff <= 1'b0;
      lowv_s2_ff <= 1'b0;
    end else begin
      lowv_s1_ff <= brownout;
      lowv_s2_ff <= lowv_s1_ff;
    end
  end

  // --------------------------------
  // reset sources
  // --------------------------------

  logic [POR_W-1:0] por_cnt_ff;
  logic por_busy;
  logic full_rst;
  logic smr_rst;
  logic stop_ff;
  logic dev_rst_ff;
  logic rec_rst_ff;

  // interval restarts on every watchdog timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_ff <= POR_LOAD;
    end else if (watchdog_timeout) begin
      por_cnt_ff <= POR_LOAD;
    end else if (por_busy) begin
      por_cnt_ff <= por_cnt_ff - 1'b1;
    end
  end

  assign por_busy = (por_cnt_ff != '0);
  assign full_rst = por_busy || watchdog_timeout || lowv_s2_ff || !pin_s2_ff;
  assign smr_rst = stop_ff && stop_wake && !full_rst;

  // external reset pin leaves stop mode untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ff <= 1'b0;
    end else if (stop_ff && stop_wake) begin
      stop_ff <= 1'b0;
    end else if (stop_enter && !full_rst) begin
      stop_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_rst_ff <= 1'b1;
      rec_rst_ff <= 1'b0;
    end else begin
      dev_rst_ff <= full_rst || smr_rst;
      rec_rst_ff <= smr_rst;
    end
  end

  // --------------------------------
  // reset pin driver
  // --------------------------------

  xrb_pin_s pin_ff;
  logic drv;

  assign drv = por_busy && !lowv_s2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff.level <= 1'b0;
      pin_ff.oe <= 1'b1;
      pin_ff.pullup_en <= 1'b0;
    end else begin
      pin_ff.level <= 1'b0;
      pin_ff.oe <= drv;
      pin_ff.pullup_en <= !drv;
    end
  end

  // --------------------------------
  // apb address decode
  // --------------------------------

  logic [7:0] rr_ff [NREG];
  logic [7:0] ur_ff [NUREG];
  logic [7:0] reg_addr;
  logic [7:0] res_addr;
  logic [11:0] key;
  logic addr_bad;
  logic in_std;
  logic in_win;
  logic in_ram;

  assign addr_bad = (paddr[31:REG_MSB+1] != '0) || (paddr[ADDR_LSB-1:0] != '0);
  assign reg_addr = paddr[REG_MSB:ADDR_LSB];

  // short working-register addresses
  always_comb begin
    res_addr = reg_addr;
    if (reg_addr[7:4] == WORK_NIB) begin
      res_addr = {rr_ff[I_RP][7:4], reg_addr[3:0]};
    end
  end

  assign in_std = (res_addr[7:4] == STD_NIB);
  assign in_win = (res_addr <= WIN_TOP);
  assign in_ram = !in_std && !in_win;

  // low window goes to the bank the pointer picks
  always_comb begin
    key = KEY_NONE;
    if (in_std) begin
      key = {BANK_STD, res_addr};
    end else if (in_win) begin
      key = {rr_ff[I_RP][3:0], res_addr};
    end
  end

  // --------------------------------
  // apb handshake
  // --------------------------------

  xrb_apb_e st_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [7:0] rd_data;
  logic [7:0] ram_rd;
  logic wr;

  assign wr = (st_ff == XRB_DONE) && psel && penable && pwrite && !addr_bad;

  // first access cycle starts the ram read, data and ready follow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= XRB_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      unique case (st_ff)
        XRB_IDLE: begin
          if (psel && penable) begin
            st_ff <= XRB_FETCH;
          end
        end
        XRB_FETCH: begin
          st_ff <= XRB_DONE;
          pready_ff <= 1'b1;
          pslverr_ff <= addr_bad;
          prdata_ff <= {24'h000000, addr_bad ? 8'h00 : rd_data};
        end
        XRB_DONE: begin
          st_ff <= XRB_IDLE;
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
        end
        default: begin
          st_ff <= XRB_IDLE;
          pready_ff <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------
  // register storage
  // --------------------------------

  logic [7:0] cap_val [NREG];
  logic cap_ld [NREG];

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      cap_ld[i] = 1'b0;
      cap_val[i] = 8'h00;
    end
    cap_ld[I_TIMER16_CAPTURE_LOW] = capture.t16_vld;
    cap_val[I_TIMER16_CAPTURE_LOW] = capture.t16_val[7:0];
    cap_ld[I_TIMER16_CAPTURE_HIGH] = capture.t16_vld;
    cap_val[I_TIMER16_CAPTURE_HIGH] = capture.t16_val[15:8];
    cap_ld[I_LO8] = capture.t8_vld;
    cap_val[I_LO8] = capture.t8_val[7:0];
    cap_ld[I_HI8] = capture.t8_vld;
    cap_val[I_HI8] = capture.t8_val[15:8];
  end

  for (genvar i = 0; i < NREG; i++) begin : g_rr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rr_ff[i] <= REG_RST[i];
      end else if (full_rst) begin
        rr_ff[i] <= REG_RST[i];
      end else if (smr_rst) begin
        rr_ff[i] <= (rr_ff[i] & REG_KEEP[i]) | (REG_RST[i] & ~REG_KEEP[i]);
      end else if (cap_ld[i]) begin
        rr_ff[i] <= cap_val[i];
      end else if (wr && key == REG_KEY[i]) begin
        rr_ff[i] <= (rr_ff[i] & ~REG_WMSK[i]) | (pwdata[7:0] & REG_WMSK[i]);
      end
    end
  end

  // no reset: contents stay unknown until software writes them
  for (genvar j = 0; j < NUREG; j++) begin : g_ur
    always_ff @(posedge pclk) begin
      if (wr && key == UREG_KEY[j]) begin
        ur_ff[j] <= pwdata[7:0];
      end
    end
  end

  xrb_ram u_ram (
    .pclk(pclk),
    .wr_en(wr && in_ram),
    .addr(res_addr),
    .wdata(pwdata[7:0]),
    .rdata(ram_rd)
  );

  // --------------------------------
  // read mux
  // --------------------------------

  // reserved and unmapped locations read zero
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (key == REG_KEY[i]) begin
        rd_data = (rr_ff[i] & REG_RMSK[i]) | REG_RONE[i];
      end
    end
    for (int j = 0; j < NUREG; j++) begin
      if (key == UREG_KEY[j]) begin
        rd_data = ur_ff[j] & UREG_RMSK[j];
      end
    end
    if (in_ram) begin
      rd_data = ram_rd;
    end
  end

  // --------------------------------
  // outputs
  // --------------------------------

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign reset_pin = pin_ff;
  assign bank_group_pointer = rr_ff[I_RP];
  assign stop_mode = stop_ff;
  assign device_reset = dev_rst_ff;
  assign recovery_reset = rec_rst_ff;

  // --------------------------------
  // checks
  // --------------------------------

  AST_DEV_RESET: assert property (
    @(posedge pclk) disable iff (!presetn)
    (watchdog_timeout || smr_rst) |=> dev_rst_ff)
    else $error("reset source did not raise device reset");

  AST_RP_CLEARED: assert property (
    @(posedge pclk) disable iff (!presetn)
    watchdog_timeout |=> rr_ff[I_RP] == REG_RST[I_RP] && por_busy)
    else $error("watchdog reset left pointer or interval wrong");

  AST_WDT_DRIVES_PIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (watchdog_timeout && !lowv_s2_ff) ##1 !lowv_s2_ff |=> pin_ff.oe)
    else $error("watchdog reset did not drive reset pin");

  AST_PULLUP_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_ff.oe |-> !pin_ff.pullup_en)
    else $error("pull-up on while pin driven");

  AST_BROWNOUT_QUIET: assert property (
    @(posedge pclk) disable iff (!presetn)
    lowv_s2_ff |=> !pin_ff.oe && pin_ff.pullup_en)
    else $error("reset pin driven under brown-out");

  AST_STOP_HOLDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    stop_ff && !stop_wake |=> stop_ff)
    else $error("stop mode left without recovery source");

  AST_KEEP_RELOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    smr_rst |=> rr_ff[I_TIMER8_LOW_RELOAD] == $past(rr_ff[I_TIMER8_LOW_RELOAD]) && rr_ff[I_P3M] == $past(rr_ff[I_P3M]))
    else $error("retained register lost on recovery");

  AST_KEEP_SMR: assert property (
    @(posedge pclk) disable iff (!presetn)
    smr_rst |=> ((rr_ff[I_SMR] ^ $past(rr_ff[I_SMR])) & REG_KEEP[I_SMR]) == 8'h00
      && ((rr_ff[I_SMR] ^ REG_RST[I_SMR]) & ~REG_KEEP[I_SMR]) == 8'h00)
    else $error("recovery config retention wrong");

  AST_KEEP_TIMER_EXTRA_CONTROL: assert property (
    @(posedge pclk) disable iff (!presetn)
    smr_rst |=> ((rr_ff[I_TIMER_EXTRA_CONTROL] ^ $past(rr_ff[I_TIMER_EXTRA_CONTROL])) & REG_KEEP[I_TIMER_EXTRA_CONTROL]) == 8'h00
      && ((rr_ff[I_TIMER_EXTRA_CONTROL] ^ REG_RST[I_TIMER_EXTRA_CONTROL]) & ~REG_KEEP[I_TIMER_EXTRA_CONTROL]) == 8'h00)
    else $error("fourth timer control retention wrong");

  AST_KEEP_TIMER16_CONTROL: assert property (
    @(posedge pclk) disable iff (!presetn)
    smr_rst |=> ((rr_ff[I_TIMER16_CONTROL] ^ $past(rr_ff[I_TIMER16_CONTROL])) & REG_KEEP[I_TIMER16_CONTROL]) == 8'h00)
    else $error("16-bit timer control retention wrong");

  AST_KEEP_TIMER_SHARED_CONTROL: assert property (
    @(posedge pclk) disable iff (!presetn)
    smr_rst |=> ((rr_ff[I_TIMER_SHARED_CONTROL] ^ $past(rr_ff[I_TIMER_SHARED_CONTROL])) & REG_KEEP[I_TIMER_SHARED_CONTROL]) == 8'h00)
    else $error("shared timer control retention wrong");

  AST_KEEP_TIMER8_CONTROL: assert property (
    @(posedge pclk) disable iff (!presetn)
    smr_rst |=> ((rr_ff[I_TIMER8_CONTROL] ^ $past(rr_ff[I_TIMER8_CONTROL])) & REG_KEEP[I_TIMER8_CONTROL]) == 8'h00
      && ((rr_ff[I_TIMER8_CONTROL] ^ REG_RST[I_TIMER8_CONTROL]) & ~REG_KEEP[I_TIMER8_CONTROL]) == 8'h00)
    else $error("8-bit timer control retention wrong");

endmodule

/* File: inc/xrb_pkg.sv */
// package: map, reset and retention tables of the expanded register bank
package xrb_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_NS = 5000;
  localparam int POR_CYC = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W = 10;
  localparam logic [POR_W-1:0] POR_LOAD = POR_W'(POR_CYC);

  localparam int ADDR_LSB = 2;
  localparam int REG_MSB = 9;
  localparam int RAM_AW = 8;
  localparam int RAM_DEPTH = 256;

  localparam logic [3:0] STD_NIB = 4'hF;
  localparam logic [3:0] WORK_NIB = 4'hE;
  localparam logic [3:0] BANK_STD = 4'h0;
  localparam logic [7:0] WIN_TOP = 8'h0F;
  localparam logic [11:0] KEY_NONE = 12'hFFF;

  // resettable registers
  localparam int NREG = 22;
  localparam int I_TIMER8_CONTROL = 0;
  localparam int I_TIMER_SHARED_CONTROL = 1;
  localparam int I_TIMER16_CONTROL = 2;
  localparam int I_TIMER_EXTRA_CONTROL = 3;
  localparam int I_TIMER8_LOW_RELOAD = 4;
  localparam int I_TIMER16_CAPTURE_LOW = 8;
  localparam int I_TIMER16_CAPTURE_HIGH = 9;
  localparam int I_LO8 = 10;
  localparam int I_HI8 = 11;
  localparam int I_SMR = 14;
  localparam int I_STOP_RECOVERY_CONFIG2 = 15;
  localparam int I_P3M = 18;
  localparam int I_RP = 21;

  localparam logic [11:0] REG_KEY [NREG] = '{
    12'hD00, 12'hD01, 12'hD02, 12'hD03, 12'hD04, 12'hD05, 12'hD06, 12'hD07,
    12'hD08, 12'hD09, 12'hD0A, 12'hD0B, 12'hD0C, 12'hF00, 12'hF0B, 12'hF0D,
    12'hF0F, 12'h0F6, 12'h0F7, 12'h0F8, 12'h0FA, 12'h0FD};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFE, 8'h20, 8'h00,
    8'h0D, 8'hFF, 8'h00, 8'hCF, 8'h00, 8'h00};
  localparam logic [7:0] REG_KEEP [NREG] = '{
    8'h3E, 8'h30, 8'h3C, 8'h20, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFE, 8'hFF,
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REG_WMSK [NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h7F, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] REG_RMSK [NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h80, 8'hA3,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
  localparam logic [7:0] REG_RONE [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // registers with no reset value
  localparam int NUREG = 9;
  localparam logic [11:0] UREG_KEY [NUREG] = '{
    12'h000, 12'h001, 12'h002, 12'h003, 12'h0F9, 12'h0FB, 12'h0FC, 12'h0FE, 12'h0FF};
  localparam logic [7:0] UREG_RMSK [NUREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  typedef struct packed {
    logic t8_vld;
    logic [15:0] t8_val;
    logic t16_vld;
    logic [15:0] t16_val;
  } xrb_cap_s;

  typedef struct packed {
    logic level;
    logic oe;
    logic pullup_en;
  } xrb_pin_s;

  typedef enum logic [1:0] {
    XRB_IDLE = 2'b00,
    XRB_FETCH = 2'b01,
    XRB_DONE = 2'b10
  } xrb_apb_e;

endpackage

/* File: hw/xrb_ram.sv */
// general-purpose register file with registered read data
`timescale 1ns/1ps
module xrb_ram (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [xrb_pkg::RAM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  import xrb_pkg::*;

  logic [7:0] mem_ff [RAM_DEPTH];
  logic [7:0] rdata_ff;

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_ff[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    rdata_ff <= mem_ff[addr];
  end

  assign rdata = rdata_ff;

endmodule

/* File: tb/xrb_core_model.sv */
// core-side model: apb master tasks and the shared open-drain reset line
`timescale 1ns/1ps
module xrb_core_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin_oe,
  input wire logic ext_low,
  output logic pin_level
);
  import xrb_pkg::*;
  // ----------------------------------------
  // reset line
  // ----------------------------------------
  // outside parts only pull low, never drive high
  assign pin_level = (pin_oe || ext_low) ? 1'b0 : 1'b1;
  // ----------------------------------------
  // apb master
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    rd = 'x;
    err = 1'bx;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // released bus shows no stale address or data
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~addr;
    pwdata <= ~wd;
  endtask
endmodule

/* File: tb/tb.sv */
// testbench: register map, retention and reset pin checks over apb
`timescale 1ns/1ps
module tb;
  import xrb_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, pin_level, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic ext_low = 1'b0;
  logic brownout = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic stop_enter = 1'b0;
  logic stop_wake = 1'b0;
  xrb_cap_s capture = '0;
  xrb_pin_s reset_pin;
  logic [7:0] bank_group_pointer;
  logic stop_mode, device_reset, recovery_reset;
  int fail_count = 0;
  int n_tests = 0;
  always #5 pclk = ~pclk;
  xrb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_level(pin_level), .reset_pin(reset_pin),
    .brownout(brownout), .watchdog_timeout(watchdog_timeout), .stop_enter(stop_enter),
    .stop_wake(stop_wake), .capture(capture), .bank_group_pointer(bank_group_pointer),
    .stop_mode(stop_mode), .device_reset(device_reset), .recovery_reset(recovery_reset));
  xrb_core_model i_core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_oe(reset_pin.oe), .ext_low(ext_low), .pin_level(pin_level));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    i_core.xfer(1'b1, {22'h0, r, 2'b00}, {24'h0, d}, x, y);
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] exp);
    logic [31:0] x;
    logic y;
    i_core.xfer(1'b0, {22'h0, r, 2'b00}, 32'h0, x, y);
    check(x, {24'h0, exp});
  endtask
  // writes to resettable registers are lost until the reset source has gone
  task automatic wait_rel();
    int n;
    n = 0;
    while (device_reset !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, device_reset}, 32'h0);
    cyc(2);
  endtask
  task automatic pin_chk(input logic oe);
    check({31'h0, reset_pin.oe}, {31'h0, oe});
    check({31'h0, reset_pin.pullup_en}, {31'h0, !oe});
    check({31'h0, reset_pin.level}, 32'h0);
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    cyc(16);
    presetn <= 1'b1;
    cyc(3);
    pin_chk(1'b1);
    wait_rel();
    cyc(3);
    pin_chk(1'b0);
    rd(8'hFD, 8'h00);
    rd(8'hFA, 8'h00);
    wr(8'hF6, 8'h12);
    rd(8'hF6, 8'h00);
    wr(8'hF2, 8'h55);
    rd(8'hF2, 8'h00);
    wr(8'hFD, 8'h3D);
    cyc(1);
    check({24'h0, bank_group_pointer}, 32'h3D);
    rd(8'h03, 8'h1F);
    rd(8'h00, 8'h00);
    wr(8'hE5, 8'hA7);
    rd(8'h35, 8'hA7);
    wr(8'h00, 8'h7F);
    wr(8'hFD, 8'h30);
    wr(8'h00, 8'h11);
    rd(8'h00, 8'h11);
    wr(8'hFD, 8'h3D);
    rd(8'h00, 8'h7F);
    wr(8'hFD, 8'h35);
    rd(8'h00, 8'h00);
    wr(8'hFD, 8'h3D);
    capture <= '{t8_vld: 1'b1, t8_val: 16'h1234, t16_vld: 1'b1, t16_val: 16'hBEEF};
    cyc(1);
    capture <= '0;
    wr(8'h0A, 8'h55);
    rd(8'h0A, 8'h34);
    rd(8'h09, 8'hBE);
    for (int i = 0; i < 4; i++) wr(8'(i), 8'hFF);
    wr(8'h04, 8'hA5);
    wr(8'hFD, 8'h3F);
    wr(8'h0D, 8'hFF);
    stop_enter <= 1'b1;
    cyc(1);
    stop_enter <= 1'b0;
    cyc(2);
    check({31'h0, stop_mode}, 32'h1);
    stop_wake <= 1'b1;
    cyc(1);
    stop_wake <= 1'b0;
    cyc(1);
    check({31'h0, recovery_reset}, 32'h1);
    cyc(3);
    check({31'h0, stop_mode}, 32'h0);
    wait_rel();
    rd(8'hFD, 8'h00);
    wr(8'hFD, 8'h3F);
    rd(8'h0D, 8'hA3);
    wr(8'hFD, 8'h3D);
    rd(8'h00, 8'h3E);
    rd(8'h01, 8'h30);
    rd(8'h02, 8'h3C);
    rd(8'h03, 8'h3F);
    rd(8'h04, 8'hA5);
    rd(8'h0A, 8'h34);
    stop_enter <= 1'b1;
    cyc(1);
    stop_enter <= 1'b0;
    ext_low <= 1'b1;
    cyc(8);
    check({31'h0, stop_mode}, 32'h1);
    ext_low <= 1'b0;
    cyc(4);
    wait_rel();
    rd(8'hFD, 8'h00);
    wr(8'hFD, 8'h3D);
    rd(8'h04, 8'h00);
    stop_wake <= 1'b1;
    cyc(1);
    stop_wake <= 1'b0;
    cyc(4);
    check({31'h0, stop_mode}, 32'h0);
    wr(8'hFD, 8'h3D);
    wr(8'h00, 8'hFF);
    watchdog_timeout <= 1'b1;
    cyc(1);
    watchdog_timeout <= 1'b0;
    cyc(4);
    pin_chk(1'b1);
    wait_rel();
    cyc(3);
    pin_chk(1'b0);
    wr(8'hFD, 8'h3D);
    rd(8'h00, 8'h00);
    brownout <= 1'b1;
    cyc(5);
    check({31'h0, device_reset}, 32'h1);
    watchdog_timeout <= 1'b1;
    cyc(1);
    watchdog_timeout <= 1'b0;
    cyc(6);
    pin_chk(1'b0);
    brownout <= 1'b0;
    cyc(4);
    wait_rel();
    i_core.xfer(1'b0, 32'h0000_0401, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    summarize();
  end
endmodule
